// ===== rtl/lic_pkg.sv
// Constants and types for the line interface control block
package lic_pkg;

  // Host port register addresses
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h78;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h79;
  localparam logic [7:0] ADDR_CTRL_FOUR = 8'h7B;
  localparam logic [7:0] ADDR_GAIN = 8'h7D;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Control one fields
  localparam int C1_TX_POWER_ON = 0;
  localparam int C1_JA_DISABLE = 1;
  localparam int C1_JA_DEPTH = 2;
  localparam int C1_JA_PLACE = 3;
  localparam int C1_EQ_LIMIT = 4;
  localparam int C1_BUILDOUT_LSB = 5;
  localparam int C1_BUILDOUT_MSB = 7;

  // Control two fields
  localparam int C2_CUSTOM_DRIVER = 0;
  localparam int C2_CLIMIT_DISABLE = 1;
  localparam int C2_LINE_STANDARD = 7;

  // Control four fields
  localparam int C4_TX_TERM_LSB = 2;
  localparam int C4_TX_TERM_MSB = 3;
  localparam int C4_MI_INVERT = 6;
  localparam int C4_MI_ENABLE = 7;

  // Gain register fields
  localparam int GN_FIELD_LSB = 0;
  localparam int GN_FIELD_MSB = 5;
  localparam int GN_AUTO_SEL = 6;
  localparam int GN_UNUSED = 7;

  // Line bit timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int E1_BIT_NS = 488;
  localparam int T1_BIT_NS = 648;
  localparam logic [6:0] E1_HALF_CYC =
    7'(E1_BIT_NS / (2 * CLK_PERIOD_NS));
  localparam logic [6:0] T1_HALF_CYC =
    7'(T1_BIT_NS / (2 * CLK_PERIOD_NS));

  typedef enum logic [1:0] {
    SENS_T1_36DB = 2'b00,
    SENS_T1_15DB = 2'b01,
    SENS_E1_12DB = 2'b10,
    SENS_E1_43DB = 2'b11
  } lic_sens_e;

  typedef enum logic [3:0] {
    SHAPE_DSX1_0 = 4'b0000,
    SHAPE_DSX1_1 = 4'b0001,
    SHAPE_DSX1_2 = 4'b0010,
    SHAPE_DSX1_3 = 4'b0011,
    SHAPE_DSX1_4 = 4'b0100,
    SHAPE_CSU_7P5 = 4'b0101,
    SHAPE_CSU_15 = 4'b0110,
    SHAPE_CSU_22P5 = 4'b0111,
    SHAPE_E1_75 = 4'b1000,
    SHAPE_E1_120 = 4'b1001,
    SHAPE_E1_75_HRL = 4'b1010,
    SHAPE_E1_120_HRL = 4'b1011,
    SHAPE_UNDEFINED = 4'b1111
  } lic_shape_e;

  typedef enum logic [1:0] {
    DRIVE_OFF = 2'b00,
    DRIVE_PUSH_PULL = 2'b01,
    DRIVE_SQUARE = 2'b10,
    DRIVE_OPEN_DRAIN = 2'b11
  } lic_drive_e;

  typedef struct packed {
    logic tx_power_on;
    logic ja_active;
    logic ja_depth_32;
    logic ja_on_tx;
    logic line_e1;
    lic_sens_e rx_sens;
    lic_shape_e tx_shape;
    lic_drive_e drive;
    logic gain_fixed;
    logic [5:0] gain_level;
    logic climit_en;
    logic mi_en;
    logic mi_inv;
  } lic_ctrl_s;

endpackage : lic_pkg

// ===== rtl/lic_cmi.sv
// Mark inversion line coder and decoder
`timescale 1ns/1ps
`default_nettype none
module lic_cmi (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Mode
  input wire logic mi_en_i,
  input wire logic mi_inv_i,
  input wire logic [6:0] half_cyc_i,
  // Transmit side
  input wire logic tx_mark_i,
  input wire logic tx_bit_stb_i,
  input wire logic tx_mid_stb_i,
  output logic tx_cmi_o,
  // Receive side
  input wire logic rx_in_i,
  output logic rx_data_o,
  output logic rx_clk_o,
  output logic rx_bit_stb_o
);

  typedef struct packed {
    logic tx_lvl;
    logic tx_zero;
    logic tx_tog;
    logic rx_prev;
    logic [7:0] rx_ph;
    logic rx_s1;
    logic rx_data;
    logic rx_clk;
    logic rx_stb;
  } lic_cmi_s;

  lic_cmi_s st_r;
  lic_cmi_s st_nxt;
  logic rx_lvl;

  assign rx_lvl = rx_in_i ^ mi_inv_i;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rx_stb = 1'b0;
    if (tx_bit_stb_i)
    begin
      st_nxt.tx_zero = ~tx_mark_i;
      if (tx_mark_i)
      begin
        st_nxt.tx_lvl = st_r.tx_tog;
        st_nxt.tx_tog = ~st_r.tx_tog;
      end
      else
      begin
        st_nxt.tx_lvl = 1'b0;
      end
    end
    else if (tx_mid_stb_i && st_r.tx_zero)
    begin
      st_nxt.tx_lvl = 1'b1;
    end
    st_nxt.rx_prev = rx_lvl;
    if (st_r.rx_prev && !rx_lvl)
    begin
      st_nxt.rx_ph = 8'h01;
    end
    else if (st_r.rx_ph >= {half_cyc_i, 1'b0} - 8'h01)
    begin
      st_nxt.rx_ph = 8'h00;
    end
    else
    begin
      st_nxt.rx_ph = st_r.rx_ph + 8'h01;
    end
    if (st_r.rx_ph == {2'b00, half_cyc_i[6:1]})
    begin
      st_nxt.rx_s1 = rx_lvl;
      st_nxt.rx_clk = 1'b1;
    end
    if (st_r.rx_ph == {1'b0, half_cyc_i} + {2'b00, half_cyc_i[6:1]})
    begin
      st_nxt.rx_data = (st_r.rx_s1 == rx_lvl);
      st_nxt.rx_clk = 1'b0;
      st_nxt.rx_stb = 1'b1;
    end
    if (!mi_en_i)
    begin
      st_nxt.rx_ph = 8'h00;
      st_nxt.rx_clk = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign tx_cmi_o = st_r.tx_lvl ^ mi_inv_i;
  assign rx_data_o = st_r.rx_data;
  assign rx_clk_o = st_r.rx_clk;
  assign rx_bit_stb_o = st_r.rx_stb;

endmodule : lic_cmi
`default_nettype wire

// ===== rtl/lic_top.sv
// Line interface control registers and line driver selection
//
// Functional notes
// - Coded one: constant level whole bit
// - Coded zero: low then high mid-bit
// - One enable bit selects coded mode
// - Zero substitution still allowed beneath coding
// - Positive receive input decoded, clock recovered
// - Power bit zero tri-states both outputs
// - Attenuator disable bit removes attenuator
// - Depth bit: 128 or 32 bits
// - Placement bit: receive or transmit path
// - Gain limit bit sets receive sensitivity
// - T1 build-out codes: cable or CSU
// - Six-bit field sets fixed gain
// - Auto select: automatic or fixed gain
// - Custom driver: square wave or open-drain
// - Limit bit disables current limiter
// - Standard bit: T1 or E1
// - Invert bit inverts coded signal
`timescale 1ns/1ps
`default_nettype none
module lic_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Host parallel port
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // Decoded control
  output lic_pkg::lic_ctrl_s ctrl_o,
  // Transmit data from line coder
  input wire logic tx_pos_i,
  input wire logic tx_neg_i,
  input wire logic tx_bit_stb_i,
  input wire logic tx_mid_stb_i,
  // Transmit line pins
  output logic tx_line_positive_o,
  output logic tx_line_positive_oe_o,
  output logic tx_line_negative_o,
  output logic tx_line_negative_oe_o,
  // Receive line pin
  input wire logic rx_line_positive_i,
  // Decoded receive stream
  output logic rx_data_o,
  output logic rx_clk_o,
  output logic rx_bit_stb_o
);

  typedef struct packed {
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [7:0] ctrl_four;
    logic [7:0] gain;
    logic wr_prev;
    logic [7:0] rdata;
    logic rdata_oe;
    lic_pkg::lic_ctrl_s ctrl;
    logic sq_tog;
    logic pos;
    logic pos_oe;
    logic neg;
    logic neg_oe;
    logic rx_data;
    logic rx_clk;
    logic rx_stb;
  } lic_top_s;

  lic_top_s st_r;
  lic_top_s st_nxt;

  logic wr_req;
  logic rd_req;
  logic [2:0] buildout;
  logic tx_mark;
  logic cmi_tx;
  logic cmi_rx_data;
  logic cmi_rx_clk;
  logic cmi_rx_stb;
  logic [6:0] half_cyc;

  assign wr_req = !cs_n_i && !wr_n_i && st_r.wr_prev;
  assign rd_req = !cs_n_i && !rd_n_i;
  assign buildout =
    st_r.ctrl_one[lic_pkg::C1_BUILDOUT_MSB:lic_pkg::C1_BUILDOUT_LSB];
  assign tx_mark = tx_pos_i | tx_neg_i;
  assign half_cyc = st_r.ctrl.line_e1 ? lic_pkg::E1_HALF_CYC :
                    lic_pkg::T1_HALF_CYC;

  lic_cmi u_cmi (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .mi_en_i(st_r.ctrl.mi_en),
    .mi_inv_i(st_r.ctrl.mi_inv),
    .half_cyc_i(half_cyc),
    .tx_mark_i(tx_mark),
    .tx_bit_stb_i(tx_bit_stb_i),
    .tx_mid_stb_i(tx_mid_stb_i),
    .tx_cmi_o(cmi_tx),
    .rx_in_i(rx_line_positive_i),
    .rx_data_o(cmi_rx_data),
    .rx_clk_o(cmi_rx_clk),
    .rx_bit_stb_o(cmi_rx_stb)
  );

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.wr_prev = cs_n_i | wr_n_i;

    // Host writes, one per low-going write strobe
    if (wr_req)
    begin
      unique case (addr_i)
        lic_pkg::ADDR_CTRL_ONE: st_nxt.ctrl_one = data_i;
        lic_pkg::ADDR_CTRL_TWO: st_nxt.ctrl_two = data_i;
        lic_pkg::ADDR_CTRL_FOUR: st_nxt.ctrl_four = data_i;
        lic_pkg::ADDR_GAIN: st_nxt.gain = data_i;
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end

    st_nxt.rdata_oe = rd_req;
    unique case (addr_i)
      lic_pkg::ADDR_CTRL_ONE: st_nxt.rdata = st_r.ctrl_one;
      lic_pkg::ADDR_CTRL_TWO: st_nxt.rdata = st_r.ctrl_two;
      lic_pkg::ADDR_CTRL_FOUR: st_nxt.rdata = st_r.ctrl_four;
      lic_pkg::ADDR_GAIN: st_nxt.rdata = st_r.gain;
      default: st_nxt.rdata = lic_pkg::UNMAPPED_READ;
    endcase

    st_nxt.ctrl.tx_power_on = st_r.ctrl_one[lic_pkg::C1_TX_POWER_ON];
    st_nxt.ctrl.ja_active = ~st_r.ctrl_one[lic_pkg::C1_JA_DISABLE];
    st_nxt.ctrl.ja_depth_32 = st_r.ctrl_one[lic_pkg::C1_JA_DEPTH];
    st_nxt.ctrl.ja_on_tx = st_r.ctrl_one[lic_pkg::C1_JA_PLACE];
    st_nxt.ctrl.line_e1 = st_r.ctrl_two[lic_pkg::C2_LINE_STANDARD];

    unique case ({st_r.ctrl_two[lic_pkg::C2_LINE_STANDARD],
                  st_r.ctrl_one[lic_pkg::C1_EQ_LIMIT]})
      2'b00: st_nxt.ctrl.rx_sens = lic_pkg::SENS_T1_36DB;
      2'b01: st_nxt.ctrl.rx_sens = lic_pkg::SENS_T1_15DB;
      2'b10: st_nxt.ctrl.rx_sens = lic_pkg::SENS_E1_12DB;
      2'b11: st_nxt.ctrl.rx_sens = lic_pkg::SENS_E1_43DB;
    endcase

    if (!st_r.ctrl_two[lic_pkg::C2_LINE_STANDARD])
    begin
      unique case (buildout)
        3'h0: st_nxt.ctrl.tx_shape = lic_pkg::SHAPE_DSX1_0;
        3'h1: st_nxt.ctrl.tx_shape = lic_pkg::SHAPE_DSX1_1;
        3'h2: st_nxt.ctrl.tx_shape = lic_pkg::SHAPE_DSX1_2;
        3'h3: st_nxt.ctrl.tx_shape = lic_pkg::SHAPE_DSX1_3;
        3'h4: st_nxt.ctrl.tx_shape = lic_pkg::SHAPE_DSX1_4;
        3'h5: st_nxt.ctrl.tx_shape = lic_pkg::SHAPE_CSU_7P5;
        3'h6: st_nxt.ctrl.tx_shape = lic_pkg::SHAPE_CSU_15;
        3'h7: st_nxt.ctrl.tx_shape = lic_pkg::SHAPE_CSU_22P5;
      endcase
    end
    else
    begin
      unique case (buildout)
        3'h0: st_nxt.ctrl.tx_shape = lic_pkg::SHAPE_E1_75;
        3'h1: st_nxt.ctrl.tx_shape = lic_pkg::SHAPE_E1_120;
        3'h4: st_nxt.ctrl.tx_shape = lic_pkg::SHAPE_E1_75_HRL;
        3'h5: st_nxt.ctrl.tx_shape = lic_pkg::SHAPE_E1_120_HRL;
        default: st_nxt.ctrl.tx_shape = lic_pkg::SHAPE_UNDEFINED;
      endcase
    end

    st_nxt.ctrl.gain_fixed = st_r.gain[lic_pkg::GN_AUTO_SEL];
    if (st_r.gain[lic_pkg::GN_AUTO_SEL])
    begin
      st_nxt.ctrl.gain_level =
        st_r.gain[lic_pkg::GN_FIELD_MSB:lic_pkg::GN_FIELD_LSB];
    end
    else
    begin
      st_nxt.ctrl.gain_level = 6'h00;
    end

    st_nxt.ctrl.climit_en = ~st_r.ctrl_two[lic_pkg::C2_CLIMIT_DISABLE];
    st_nxt.ctrl.mi_en = st_r.ctrl_four[lic_pkg::C4_MI_ENABLE];
    st_nxt.ctrl.mi_inv = st_r.ctrl_four[lic_pkg::C4_MI_INVERT];

    if (!st_r.ctrl_one[lic_pkg::C1_TX_POWER_ON])
    begin
      st_nxt.ctrl.drive = lic_pkg::DRIVE_OFF;
    end
    else if (!st_r.ctrl_two[lic_pkg::C2_CUSTOM_DRIVER])
    begin
      st_nxt.ctrl.drive = lic_pkg::DRIVE_PUSH_PULL;
    end
    else if (buildout == 3'h0)
    begin
      st_nxt.ctrl.drive = lic_pkg::DRIVE_SQUARE;
    end
    else
    begin
      st_nxt.ctrl.drive = lic_pkg::DRIVE_OPEN_DRAIN;
    end

    // Square wave toggles once per transmit bit
    if (tx_bit_stb_i)
    begin
      st_nxt.sq_tog = ~st_r.sq_tog;
    end

    // Line driver outputs
    unique case (st_r.ctrl.drive)
      lic_pkg::DRIVE_OFF:
      begin
        st_nxt.pos = 1'b0;
        st_nxt.pos_oe = 1'b0;
        st_nxt.neg = 1'b0;
        st_nxt.neg_oe = 1'b0;
      end
      lic_pkg::DRIVE_SQUARE:
      begin
        st_nxt.pos = st_r.sq_tog;
        st_nxt.pos_oe = 1'b1;
        st_nxt.neg = ~st_r.sq_tog;
        st_nxt.neg_oe = 1'b1;
      end
      lic_pkg::DRIVE_OPEN_DRAIN:
      begin
        // Pull low on a pulse, or while the coded level is low, release otherwise
        st_nxt.pos = 1'b0;
        st_nxt.pos_oe = st_r.ctrl.mi_en ? ~cmi_tx : tx_pos_i;
        st_nxt.neg = 1'b0;
        st_nxt.neg_oe = st_r.ctrl.mi_en ? 1'b0 : tx_neg_i;
      end
      lic_pkg::DRIVE_PUSH_PULL:
      begin
        st_nxt.pos = st_r.ctrl.mi_en ? cmi_tx : tx_pos_i;
        st_nxt.pos_oe = 1'b1;
        st_nxt.neg = st_r.ctrl.mi_en ? 1'b0 : tx_neg_i;
        st_nxt.neg_oe = 1'b1;
      end
    endcase

    st_nxt.rx_data = st_r.ctrl.mi_en ? cmi_rx_data : rx_line_positive_i;
    st_nxt.rx_clk = st_r.ctrl.mi_en & cmi_rx_clk;
    st_nxt.rx_stb = st_r.ctrl.mi_en & cmi_rx_stb;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= '0;
      st_r.ctrl_one <= lic_pkg::REG_RESET;
      st_r.ctrl_two <= lic_pkg::REG_RESET;
      st_r.ctrl_four <= lic_pkg::REG_RESET;
      st_r.gain <= lic_pkg::REG_RESET;
      st_r.wr_prev <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign data_o = st_r.rdata;
  assign data_oe_o = st_r.rdata_oe;
  assign ctrl_o = st_r.ctrl;
  assign tx_line_positive_o = st_r.pos;
  assign tx_line_positive_oe_o = st_r.pos_oe;
  assign tx_line_negative_o = st_r.neg;
  assign tx_line_negative_oe_o = st_r.neg_oe;
  assign rx_data_o = st_r.rx_data;
  assign rx_clk_o = st_r.rx_clk;
  assign rx_bit_stb_o = st_r.rx_stb;

endmodule : lic_top
`default_nettype wire

// ===== verif/lic_line_model.sv
// Optical module model that loops the coded line back
`timescale 1ns/1ps
`default_nettype none
module lic_line_model (
  // Clock
  input wire logic clk_sys_i,
  // Transmit pin from the block
  input wire logic tx_i,
  input wire logic tx_oe_i,
  // Receive pin to the block
  output logic rx_o
);
  logic last_r = 1'b0;
  always_ff @(posedge clk_sys_i)
    if (tx_oe_i)
      last_r <= tx_i;
  // Released line shows the inverse level
  assign rx_o = tx_oe_i ? tx_i : ~last_r;
endmodule : lic_line_model
`default_nettype wire

// ===== verif/lic_top_properties.sv
// Assertion checker for the line interface control block
`timescale 1ns/1ps
`default_nettype none
module lic_top_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Host port
  input wire logic cs_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] data_i,
  input wire lic_pkg::lic_ctrl_s ctrl_o,
  // Line side
  input wire logic tx_pos_i,
  input wire logic tx_neg_i,
  input wire logic tx_bit_stb_i,
  input wire logic tx_line_positive_o,
  input wire logic tx_line_positive_oe_o,
  input wire logic tx_line_negative_oe_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  logic idle_r;
  logic tk;
  logic w1;
  logic w2;
  logic w4;
  logic wg;
  logic mi_pp;
  // Write is taken once per strobe
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
      idle_r <= 1'b1;
    else
      idle_r <= cs_n_i | wr_n_i;
  assign tk = idle_r & ~cs_n_i & ~wr_n_i;
  assign w1 = tk && addr_i == lic_pkg::ADDR_CTRL_ONE;
  assign w2 = tk && addr_i == lic_pkg::ADDR_CTRL_TWO;
  assign w4 = tk && addr_i == lic_pkg::ADDR_CTRL_FOUR;
  assign wg = tk && addr_i == lic_pkg::ADDR_GAIN;
  assign mi_pp = ctrl_o.mi_en && tx_bit_stb_i
    && ctrl_o.drive == lic_pkg::DRIVE_PUSH_PULL;
  property p_power;
    w1 |-> ##2 ctrl_o.tx_power_on == $past(data_i[0], 2);
  endproperty
  a_power: assert property (p_power)
    else $error("power bit not applied");
  property p_tri;
    $past(!ctrl_o.tx_power_on)
      |-> !tx_line_positive_oe_o && !tx_line_negative_oe_o;
  endproperty
  a_tri: assert property (p_tri)
    else $error("pins driven while powered down");
  property p_ja;
    w1 |-> ##2 ctrl_o.ja_active != $past(data_i[1], 2)
      && ctrl_o.ja_depth_32 == $past(data_i[2], 2)
      && ctrl_o.ja_on_tx == $past(data_i[3], 2);
  endproperty
  a_ja: assert property (p_ja)
    else $error("attenuator controls wrong");
  property p_sens;
    w1 |-> ##2 ctrl_o.rx_sens == {ctrl_o.line_e1, $past(data_i[4], 2)};
  endproperty
  a_sens: assert property (p_sens)
    else $error("receive sensitivity wrong");
  property p_std;
    w2 |-> ##2 ctrl_o.line_e1 == $past(data_i[7], 2)
      && ctrl_o.climit_en != $past(data_i[1], 2);
  endproperty
  a_std: assert property (p_std)
    else $error("standard or limiter wrong");
  property p_gain;
    wg |-> ##2 ctrl_o.gain_fixed == $past(data_i[6], 2);
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain select wrong");
  property p_level;
    wg && data_i[6] |-> ##2 ctrl_o.gain_level == $past(data_i[5:0], 2);
  endproperty
  a_level: assert property (p_level)
    else $error("fixed gain level wrong");
  property p_mode;
    w4 |-> ##2 ctrl_o.mi_en == $past(data_i[7], 2)
      && ctrl_o.mi_inv == $past(data_i[6], 2);
  endproperty
  a_mode: assert property (p_mode)
    else $error("coding mode wrong");
  property p_zero;
    mi_pp && !(tx_pos_i | tx_neg_i)
      |-> ##2 tx_line_positive_o == ctrl_o.mi_inv;
  endproperty
  a_zero: assert property (p_zero)
    else $error("coded zero not low first");
  property p_one;
    mi_pp && (tx_pos_i | tx_neg_i)
      |-> ##3 $stable(tx_line_positive_o) [*8];
  endproperty
  a_one: assert property (p_one)
    else $error("coded one level moved");
  cover property (w1);
  cover property (mi_pp);
  cover property (ctrl_o.drive == lic_pkg::DRIVE_SQUARE);
endmodule : lic_top_chk
bind lic_top lic_top_chk u_chk (
  .clk_sys_i,
  .rst_n_i,
  .cs_n_i,
  .wr_n_i,
  .addr_i,
  .data_i,
  .ctrl_o,
  .tx_pos_i,
  .tx_neg_i,
  .tx_bit_stb_i,
  .tx_line_positive_o,
  .tx_line_positive_oe_o,
  .tx_line_negative_oe_o
);
`default_nettype wire

// ===== verif/tb.sv
// Self-checking testbench for the line interface control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [15:0] TX_PAT = 16'h6B2D;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cs_n_i = 1'b1;
  logic rd_n_i = 1'b1;
  logic wr_n_i = 1'b1;
  logic tx_pos_i = 1'b0;
  logic tx_neg_i = 1'b0;
  logic tx_bit_stb_i = 1'b0;
  logic tx_mid_stb_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] data_i = 8'h00;
  logic [7:0] data_o;
  logic data_oe_o;
  lic_pkg::lic_ctrl_s ctrl_o;
  logic tx_line_positive_o;
  logic tx_line_positive_oe_o;
  logic tx_line_negative_o;
  logic tx_line_negative_oe_o;
  logic rx_line_positive_i;
  logic rx_data_o;
  logic rx_bit_stb_o;
  logic rx_clk_o;
  logic [7:0] hi_cnt;
  logic [7:0] hi_last;
  logic [7:0] rm [8];
  logic [7:0] gv [4] = '{8'h2A, 8'h6A, 8'h7F, 8'h40};
  logic [7:0] rx_hist;
  logic tog;
  logic inv;
  logic lvl;
  int rx_cnt;
  int hb;
  int num_errors = 0;
  int cmp_count = 0;
  lic_top u_dut (
    .clk_sys_i,
    .rst_n_i,
    .cs_n_i,
    .rd_n_i,
    .wr_n_i,
    .addr_i,
    .data_i,
    .data_o,
    .data_oe_o,
    .ctrl_o,
    .tx_pos_i,
    .tx_neg_i,
    .tx_bit_stb_i,
    .tx_mid_stb_i,
    .tx_line_positive_o,
    .tx_line_positive_oe_o,
    .tx_line_negative_o,
    .tx_line_negative_oe_o,
    .rx_line_positive_i,
    .rx_data_o,
    .rx_clk_o,
    .rx_bit_stb_o
  );
  lic_line_model u_line (
    .clk_sys_i,
    .tx_i(tx_line_positive_o),
    .tx_oe_i(tx_line_positive_oe_o),
    .rx_o(rx_line_positive_i)
  );
  initial forever #5 clk_sys_i = ~clk_sys_i;
  // Recovered clock high time measured per decoded bit
  always @(posedge clk_sys_i)
    if (rx_bit_stb_o === 1'b1)
    begin
      rx_hist <= {rx_hist[6:0], rx_data_o};
      rx_cnt <= rx_cnt + 1;
      hi_last <= hi_cnt;
      hi_cnt <= 8'h00;
    end
    else if (rx_clk_o === 1'b1)
    begin
      hi_cnt <= hi_cnt + 8'h01;
    end
  function automatic lic_pkg::lic_ctrl_s exp_ctrl();
    lic_pkg::lic_ctrl_s e;
    logic [7:0] r1;
    logic [3:0] sh;
    r1 = rm[0];
    sh = {1'b0, r1[7:5]};
    if (rm[1][7])
      sh = r1[6] ? 4'hF : {2'b10, r1[7], r1[5]};
    e.tx_power_on = r1[0];
    e.ja_active = ~r1[1];
    e.ja_depth_32 = r1[2];
    e.ja_on_tx = r1[3];
    e.line_e1 = rm[1][7];
    e.rx_sens = lic_pkg::lic_sens_e'({rm[1][7], r1[4]});
    e.tx_shape = lic_pkg::lic_shape_e'(sh);
    e.drive = lic_pkg::lic_drive_e'({r1[0] & rm[1][0],
      r1[0] & (~rm[1][0] | (|r1[7:5]))});
    e.gain_fixed = rm[5][6];
    e.gain_level = rm[5][6] ? rm[5][5:0] : 6'h00;
    e.climit_en = ~rm[1][1];
    e.mi_en = rm[3][7];
    e.mi_inv = rm[3][6];
    return e;
  endfunction : exp_ctrl
  function automatic logic ok(input logic [7:0] a);
    return a inside {lic_pkg::ADDR_CTRL_ONE, lic_pkg::ADDR_CTRL_TWO,
      lic_pkg::ADDR_CTRL_FOUR, lic_pkg::ADDR_GAIN};
  endfunction : ok
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic cc();
    lic_pkg::lic_ctrl_s e;
    e = exp_ctrl();
    repeat (3) @(negedge clk_sys_i);
    cmp_count++;
    if (ctrl_o !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, ctrl_o, e);
    end
  endtask : cc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    cs_n_i = 1'b0;
    wr_n_i = 1'b0;
    addr_i = a;
    data_i = d;
    if (ok(a))
      rm[a[2:0]] = d;
    @(negedge clk_sys_i);
    cs_n_i = 1'b1;
    wr_n_i = 1'b1;
  endtask : wr
  task automatic rdall();
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk_sys_i);
      cs_n_i = 1'b0;
      rd_n_i = 1'b0;
      addr_i = 8'h78 + 8'(i);
      @(negedge clk_sys_i);
      chk(data_o, ok(addr_i) ? rm[i] : lic_pkg::UNMAPPED_READ);
      chk({7'h00, data_oe_o}, 8'h01);
    end
    cs_n_i = 1'b1;
    rd_n_i = 1'b1;
  endtask : rdall
  task automatic pins(input logic [1:0] e);
    chk({6'h00, tx_line_positive_o, tx_line_negative_o}, {6'h00, e});
  endtask : pins
  task automatic send(input logic m);
    @(negedge clk_sys_i);
    tx_pos_i = m & ~tog;
    tx_neg_i = m & tog;
    tx_bit_stb_i = 1'b1;
    @(negedge clk_sys_i);
    tx_bit_stb_i = 1'b0;
    lvl = m ? tog ^ inv : inv;
    repeat (hb / 2 - 1) @(negedge clk_sys_i);
    pins({lvl, 1'b0});
    repeat (hb / 2) @(negedge clk_sys_i);
    tx_mid_stb_i = 1'b1;
    @(negedge clk_sys_i);
    tx_mid_stb_i = 1'b0;
    lvl = m ? lvl : ~inv;
    repeat (hb / 2 - 1) @(negedge clk_sys_i);
    pins({lvl, 1'b0});
    tog = tog ^ m;
    repeat (hb / 2 - 1) @(negedge clk_sys_i);
  endtask : send
  task automatic do_reset();
    rst_n_i = 1'b0;
    rm = '{default: 8'h00};
    repeat (10) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
  endtask : do_reset
  task automatic close_out();
    $display("Compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    close_out();
  end
  initial
  begin
    do_reset();
    wr(8'h7A, 8'h5A);
    cc();
    chk({7'h00, data_oe_o}, 8'h00);
    rdall();
    $display("Test reset done");
    for (int i = 0; i < 16; i++)
    begin
      wr(lic_pkg::ADDR_CTRL_TWO, {i[3], 7'h02});
      wr(lic_pkg::ADDR_CTRL_ONE, {i[2:0], 5'(i * 5)});
      cc();
      chk({6'h00, tx_line_positive_oe_o, tx_line_negative_oe_o},
        {6'h00, {2{rm[0][0]}}});
      rdall();
    end
    $display("Test line settings done");
    foreach (gv[i])
    begin
      wr(lic_pkg::ADDR_GAIN, gv[i]);
      cc();
    end
    rdall();
    $display("Test gain done");
    wr(lic_pkg::ADDR_CTRL_ONE, 8'h01);
    wr(lic_pkg::ADDR_CTRL_TWO, 8'h01);
    cc();
    for (int i = 0; i < 2; i++)
    begin
      lvl = tx_line_positive_o;
      @(negedge clk_sys_i);
      tx_bit_stb_i = 1'b1;
      @(negedge clk_sys_i);
      tx_bit_stb_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      pins({~lvl, lvl});
    end
    wr(lic_pkg::ADDR_CTRL_ONE, 8'h61);
    cc();
    pins(2'b00);
    wr(lic_pkg::ADDR_CTRL_ONE, 8'h60);
    cc();
    chk({6'h00, tx_line_positive_oe_o, tx_line_negative_oe_o}, 8'h00);
    wr(lic_pkg::ADDR_CTRL_TWO, 8'h00);
    $display("Test driver modes done");
    for (int k = 0; k < 3; k++)
    begin
      do_reset();
      inv = k[0];
      tog = 1'b0;
      hb = k[1] ? lic_pkg::E1_HALF_CYC : lic_pkg::T1_HALF_CYC;
      wr(lic_pkg::ADDR_CTRL_TWO, {k[1], 7'h00});
      wr(lic_pkg::ADDR_CTRL_FOUR, {1'b1, inv, 6'h00});
      wr(lic_pkg::ADDR_CTRL_ONE, 8'h01);
      cc();
      rx_cnt <= 0;
      for (int b = 15; b >= 0; b--)
        send(TX_PAT[b]);
      chk(rx_hist, TX_PAT[7:0]);
      chk({7'h00, rx_cnt > 8}, 8'h01);
      chk(hi_last, 8'(hb));
      $display("Test coded line done");
    end
    close_out();
  end
endmodule : tb
`default_nettype wire
